// ==== core/tai_consts.svh ====
// Constants for the threshold adjust interval decoder.
// Assumes inclusion by bare name from core files and from the sim bench.
`ifndef TAI_CONSTS_SVH
`define TAI_CONSTS_SVH

// Register offsets on the plain register port
`define TAI_ADDR_COMPANION 8'h36
`define TAI_ADDR_CONFIG    8'h37
`define TAI_ADDR_STATUS    8'hF0

// Reset values
`define TAI_CONFIG_RESET    8'h00
`define TAI_COMPANION_RESET 8'h00
`define TAI_COUNT_RESET     12'h000
`define TAI_RDATA_IDLE      8'h00

// Field positions in the configuration register
`define TAI_R1_MSB    2
`define TAI_R1_LSB    0
`define TAI_LOCAL_MSB 5
`define TAI_LOCAL_LSB 3
`define TAI_R2LO_MSB  7
`define TAI_R2LO_LSB  6
// Remote 2 code top bit in the companion register
`define TAI_R2HI_BIT  0

// Decrease interval for code 000, in monitoring cycles
`define TAI_DEC_BASE  12'h008
`define TAI_COUNT_ONE 12'h001

`endif

// ==== core/tai_pkg.sv ====
// Types and decode helpers for the threshold adjust interval decoder.
// Assumes tai_consts.svh sits beside this file.
`include "tai_consts.svh"

package tai_pkg;

	// Interval count width: 12 bits, holds up to 4095 cycles
	typedef logic [11:0] tai_count_t;
	typedef logic [2:0]  tai_code_t;

	// Per-channel control from the adjustment loop
	typedef struct packed {
		logic enable;
		logic restart;
	} tai_chan_ctl_s;

	// Per-channel interval state back to the loop
	typedef struct packed {
		logic dec_ready;
		logic inc_ready;
	} tai_chan_stat_s;

	// Decrease interval: base times two to the code
	function automatic tai_count_t tai_decrease_cycles(input tai_code_t code);
		tai_decrease_cycles = tai_count_t'(`TAI_DEC_BASE << code);
	endfunction

	// Increase interval: twice the decrease interval
	function automatic tai_count_t tai_increase_cycles(input tai_code_t code);
		tai_increase_cycles = tai_count_t'(`TAI_DEC_BASE << code) << 1;
	endfunction

endpackage

// ==== core/tai_interval_counter.sv ====
// One channel's interval counter for start temperature adjustments.
// Assumes a one-cycle monitor tick and restart pulse on the same clock.
`include "tai_consts.svh"

module tai_interval_counter
	import tai_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// Timing and control
	input  wire logic       tick,
	input  wire tai_code_t  code,
	input  wire tai_chan_ctl_s ctl,
	// Interval state
	output tai_chan_stat_s  stat,
	output tai_count_t      count
);

	tai_count_t next_count;
	tai_count_t dec_cycles;
	tai_count_t inc_cycles;

	// Both thresholds come from the same code
	assign dec_cycles = tai_decrease_cycles(code);
	assign inc_cycles = tai_increase_cycles(code);

	// Count ticks since the last adjustment, saturating at the longer interval
	always_comb begin
		next_count = count;
		if (!ctl.enable || ctl.restart) begin
			next_count = `TAI_COUNT_RESET;
		end else if (tick && count < inc_cycles) begin
			next_count = count + `TAI_COUNT_ONE;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count <= `TAI_COUNT_RESET;
		end else begin
			count <= next_count;
		end
	end

	// Ready flags compare against the live code, so a code change acts at once
	assign stat = '{dec_ready: ctl.enable && (count >= dec_cycles),
		inc_ready: ctl.enable && (count >= inc_cycles)};

	a_restart_clears: assert property (@(posedge clock) disable iff (!reset_n)
		ctl.restart |=> count == `TAI_COUNT_RESET)
		else $error("count not cleared after restart");

	a_inc_after_dec: assert property (@(posedge clock) disable iff (!reset_n)
		stat.inc_ready |-> stat.dec_ready && count >= (dec_cycles << 1))
		else $error("increase ready before twice the decrease interval");

	a_dec_on_time: assert property (@(posedge clock) disable iff (!reset_n)
		(tick && ctl.enable && !ctl.restart && count == dec_cycles - `TAI_COUNT_ONE
		&& $stable(code)) ##1 ($stable(code) && ctl.enable) |-> stat.dec_ready)
		else $error("decrease interval not reached on its tick");

endmodule

// ==== core/tai_top.sv ====
// Threshold adjust interval decoder: register file plus three channel counters.
// Assumes the monitor tick and lock come from logic on the same clock.
//
// Functional notes
// - Local interval code sits in config bits [5:3], read and write.
// - Each channel waits its coded number of monitor cycles between adjustments.
// - Decrease interval is 8 cycles times two to the code.
// - Increase interval is twice the decrease interval.
// - Remote 2 code low two bits sit in config bits [7:6].
// - Remote 2 top bit comes from the companion register at 0x36.
// - Remote 1 code sits in config bits [2:0], same table.
// - Remote 2 top bit is companion register bit 0.
// - Once locked, config writes are ignored until power cycles; here writes are blocked only while config_lock is high.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`include "tai_consts.svh"

module tai_top
	import tai_pkg::*;
#(
	parameter int NUM_CHAN = 3
)
(
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          reset_n,
	// Register port
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_write,
	input  wire logic          reg_read,
	output logic [7:0]         reg_rdata,
	// Lock from the configuration register
	input  wire logic          config_lock,
	// Monitoring cycle tick
	input  wire logic          monitor_tick,
	// Channels: 0 local, 1 remote 1, 2 remote 2
	input  wire tai_chan_ctl_s chan_ctl  [NUM_CHAN],
	output tai_chan_stat_s     chan_stat [NUM_CHAN],
	// Decoded codes for the adjustment loop
	output tai_code_t          local_interval_code,
	output tai_code_t          remote1_interval_code,
	output tai_code_t          remote2_interval_code
);

	logic [7:0] interval_config;
	logic [7:0] next_interval_config;
	logic       companion_msb;
	logic       next_companion_msb;
	logic [7:0] next_reg_rdata;
	logic [7:0] status_bits;
	logic       write_ok;
	tai_code_t  codes [NUM_CHAN];

	// Lock gates every write to both lockable registers
	assign write_ok = reg_write && !config_lock;

	// Register writes
	always_comb begin
		next_interval_config = interval_config;
		next_companion_msb   = companion_msb;
		if (write_ok && reg_addr == `TAI_ADDR_CONFIG) begin
			next_interval_config = reg_wdata;
		end
		if (write_ok && reg_addr == `TAI_ADDR_COMPANION) begin
			next_companion_msb = reg_wdata[`TAI_R2HI_BIT];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			interval_config <= `TAI_CONFIG_RESET;
			companion_msb   <= 1'(`TAI_COMPANION_RESET >> `TAI_R2HI_BIT);
		end else begin
			interval_config <= next_interval_config;
			companion_msb   <= next_companion_msb;
		end
	end

	// Field decode into per-channel codes
	assign local_interval_code   = interval_config[`TAI_LOCAL_MSB:`TAI_LOCAL_LSB];
	assign remote1_interval_code = interval_config[`TAI_R1_MSB:`TAI_R1_LSB];
	assign remote2_interval_code = {companion_msb,
		interval_config[`TAI_R2LO_MSB:`TAI_R2LO_LSB]};
	assign codes[0] = local_interval_code;
	assign codes[1] = remote1_interval_code;
	assign codes[2] = remote2_interval_code;

	// One counter per channel, all on the shared tick
	for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
		tai_interval_counter u_counter (
			.clock   (clock),
			.reset_n (reset_n),
			.tick    (monitor_tick),
			.code    (codes[i]),
			.ctl     (chan_ctl[i]),
			.stat    (chan_stat[i]),
			.count   ()
		);
	end

	// Status: ready flags packed two per channel, top bits zero
	always_comb begin
		status_bits = 8'h00;
		for (int i = 0; i < NUM_CHAN; i++) begin
			status_bits[2 * i]     = chan_stat[i].dec_ready;
			status_bits[2 * i + 1] = chan_stat[i].inc_ready;
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_comb begin
		next_reg_rdata = `TAI_RDATA_IDLE;
		if (reg_read) begin
			case (reg_addr)
				`TAI_ADDR_CONFIG: begin
					next_reg_rdata = interval_config;
				end
				`TAI_ADDR_COMPANION: begin
					next_reg_rdata = {7'h00, companion_msb};
				end
				`TAI_ADDR_STATUS: begin
					next_reg_rdata = status_bits;
				end
				default: begin
					next_reg_rdata = `TAI_RDATA_IDLE; // Unmapped reads as zero
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `TAI_RDATA_IDLE;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// Checks on register behaviour and decode

	a_cfg_write_takes: assert property (@(posedge clock) disable iff (!reset_n)
		reg_write && !config_lock && reg_addr == `TAI_ADDR_CONFIG
		|=> interval_config == $past(reg_wdata))
		else $error("config write not stored");

	a_lock_blocks_write: assert property (@(posedge clock) disable iff (!reset_n)
		config_lock |=> $stable(interval_config) && $stable(companion_msb))
		else $error("locked register changed");

	a_remote2_join: assert property (@(posedge clock) disable iff (!reset_n)
		reg_write && !config_lock && reg_addr == `TAI_ADDR_COMPANION
		|=> remote2_interval_code[2] == $past(reg_wdata[`TAI_R2HI_BIT]))
		else $error("remote 2 top bit not taken from companion");

	a_remote2_low: assert property (@(posedge clock) disable iff (!reset_n)
		reg_write && !config_lock && reg_addr == `TAI_ADDR_CONFIG
		|=> remote2_interval_code[1:0] == $past(reg_wdata[7:6]))
		else $error("remote 2 low bits wrong");

	a_local_field: assert property (@(posedge clock) disable iff (!reset_n)
		reg_write && !config_lock && reg_addr == `TAI_ADDR_CONFIG
		|=> local_interval_code == $past(reg_wdata[5:3]))
		else $error("local code field wrong");

	a_remote1_field: assert property (@(posedge clock) disable iff (!reset_n)
		reg_write && !config_lock && reg_addr == `TAI_ADDR_CONFIG
		|=> remote1_interval_code == $past(reg_wdata[2:0]))
		else $error("remote 1 code field wrong");

	a_read_config: assert property (@(posedge clock) disable iff (!reset_n)
		reg_read && reg_addr == `TAI_ADDR_CONFIG |=> reg_rdata == $past(interval_config))
		else $error("config read data wrong");

	// Read port data and its idle level
	a_read_companion: assert property (@(posedge clock) disable iff (!reset_n)
		reg_read && reg_addr == `TAI_ADDR_COMPANION
		|=> reg_rdata == {7'h00, $past(companion_msb)})
		else $error("companion read data wrong");

	a_read_status: assert property (@(posedge clock) disable iff (!reset_n)
		reg_read && reg_addr == `TAI_ADDR_STATUS |=> reg_rdata == $past(status_bits))
		else $error("status read data wrong");

	a_rdata_idle: assert property (@(posedge clock) disable iff (!reset_n)
		!reg_read |=> reg_rdata == `TAI_RDATA_IDLE)
		else $error("read data held past its cycle");

	// Registers move only on an accepted write, so a stray strobe cannot retune a loop
	a_config_hold: assert property (@(posedge clock) disable iff (!reset_n)
		!(reg_write && !config_lock && reg_addr == `TAI_ADDR_CONFIG)
		|=> $stable(interval_config))
		else $error("config changed without a write");

	a_companion_hold: assert property (@(posedge clock) disable iff (!reset_n)
		!(reg_write && !config_lock && reg_addr == `TAI_ADDR_COMPANION)
		|=> $stable(companion_msb))
		else $error("companion changed without a write");

	a_local_ready_rise: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(chan_stat[0].dec_ready) |-> $past(monitor_tick) || $changed(local_interval_code))
		else $error("local ready rose without a tick");

	a_restart_drops: assert property (@(posedge clock) disable iff (!reset_n)
		chan_ctl[0].restart && chan_ctl[0].enable ##1 chan_ctl[0].enable
		|-> !chan_stat[0].dec_ready && !chan_stat[0].inc_ready)
		else $error("ready still set after restart");

	// Remote channels: ready rises only on a tick or a code change, and remote 2 ready drops on restart
	a_remote1_ready_rise: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(chan_stat[1].dec_ready) |-> $past(monitor_tick) || $changed(remote1_interval_code))
		else $error("remote 1 ready rose without a tick");

	a_remote2_ready_rise: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(chan_stat[2].dec_ready) |-> $past(monitor_tick) || $changed(remote2_interval_code))
		else $error("remote 2 ready rose without a tick");

	a_remote2_restart: assert property (@(posedge clock) disable iff (!reset_n)
		chan_ctl[2].restart && chan_ctl[2].enable ##1 chan_ctl[2].enable
		|-> !chan_stat[2].dec_ready && !chan_stat[2].inc_ready)
		else $error("remote 2 ready still set after restart");

endmodule

// ==== sim/tb_threshold_adjust_interval_decode.sv ====
// Self-checking bench for the interval decoder: register port, codes, counters, lock.
// Assumes tai_top with three channels and the register offsets of tai_consts.svh.
`include "tai_consts.svh"

module tb_threshold_adjust_interval_decode
	import tai_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int LIMIT = 40000;

	logic           clock         = 1'b0;
	logic           reset_n       = 1'b0;
	logic [7:0]     reg_addr      = 8'h00;
	logic [7:0]     reg_wdata     = 8'h00;
	logic           reg_write     = 1'b0;
	logic           reg_read      = 1'b0;
	logic [7:0]     reg_rdata;
	logic           config_lock   = 1'b0;
	logic           monitor_tick  = 1'b0;
	tai_chan_ctl_s  chan_ctl [3]  = '{default: '0};
	tai_chan_stat_s chan_stat [3];
	tai_code_t      codes [3];
	int             miscompares   = 0;
	int             samples_checked = 0;
	int             cycles        = 0;

	tai_top u_dut (
		.clock                 (clock),
		.reset_n               (reset_n),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_write             (reg_write),
		.reg_read              (reg_read),
		.reg_rdata             (reg_rdata),
		.config_lock           (config_lock),
		.monitor_tick          (monitor_tick),
		.chan_ctl              (chan_ctl),
		.chan_stat             (chan_stat),
		.local_interval_code   (codes[0]),
		.remote1_interval_code (codes[1]),
		.remote2_interval_code (codes[2])
	);

	// Free-running 20 MHz clock
	always #25 clock = ~clock;

	// Hang guard: a stuck run still ends in the report
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			final_report();
		end
	end

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Compare tasks, one per kind of result
	task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: data %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_code(input tai_code_t got, input tai_code_t exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: code %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flags(input tai_chan_stat_s got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: flags %b, expected %b", $time, got, exp);
		end
	endtask

	// One-cycle write strobe, released at the edge that takes it
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// Read data is looked at only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= addr;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		chk_data(reg_rdata, exp);
	endtask

	// Back-to-back ticks, flags sampled after the last one lands
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clock);
			monitor_tick <= 1'b1;
		end
		@(posedge clock);
		monitor_tick <= 1'b0;
		@(negedge clock);
	endtask

	// Walk one channel through both intervals of the current code
	task automatic run_chan(input int ch, input tai_code_t c);
		int dec;
		dec = 8 << c;
		@(posedge clock);
		chan_ctl[ch] <= '{enable: 1'b1, restart: 1'b1};
		@(posedge clock);
		chan_ctl[ch].restart <= 1'b0;
		ticks(dec - 1);
		chk_flags(chan_stat[ch], 2'b00);
		ticks(1);
		chk_flags(chan_stat[ch], 2'b10);
		ticks(dec - 1);
		chk_flags(chan_stat[ch], 2'b10);
		ticks(1);
		chk_flags(chan_stat[ch], 2'b11);
		rd_chk(`TAI_ADDR_STATUS, 8'h03 << (2 * ch));
		@(posedge clock);
		chan_ctl[ch].restart <= 1'b1;
		@(posedge clock);
		chan_ctl[ch] <= '{enable: 1'b0, restart: 1'b0};
		@(negedge clock);
		chk_flags(chan_stat[ch], 2'b00);
	endtask

	// Main sequence
	initial begin
		logic [7:0] cfg;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		rd_chk(`TAI_ADDR_CONFIG, 8'h00);
		rd_chk(`TAI_ADDR_COMPANION, 8'h00);
		rd_chk(8'h55, 8'h00);
		// Codes 6, 5 and 6 from separate bit fields show each field lands in its own place
		wr(`TAI_ADDR_CONFIG, 8'hB5);
		wr(`TAI_ADDR_COMPANION, 8'h01);
		rd_chk(`TAI_ADDR_CONFIG, 8'hB5);
		rd_chk(`TAI_ADDR_COMPANION, 8'h01);
		chk_code(codes[0], 3'h6);
		chk_code(codes[1], 3'h5);
		chk_code(codes[2], 3'h6);
		// Every code on every channel
		for (int c = 0; c < 8; c++) begin
			cfg = {c[1:0], c[2:0], c[2:0]};
			wr(`TAI_ADDR_CONFIG, cfg);
			wr(`TAI_ADDR_COMPANION, {7'h00, c[2]});
			@(negedge clock);
			chk_code(codes[2], c[2:0]);
			for (int ch = 0; ch < 3; ch++) begin
				chk_code(codes[ch], c[2:0]);
				run_chan(ch, c[2:0]);
			end
		end
		// Locked registers keep their last contents
		@(posedge clock);
		config_lock <= 1'b1;
		wr(`TAI_ADDR_CONFIG, 8'h00);
		wr(`TAI_ADDR_COMPANION, 8'h00);
		rd_chk(`TAI_ADDR_CONFIG, 8'hFF);
		rd_chk(`TAI_ADDR_COMPANION, 8'h01);
		chk_code(codes[2], 3'h7);
		final_report();
	end
endmodule
